// *** common/ulpe_map.vh ***
// register map, field positions, reset values and timing for the low-power serial port
// assumes a 32-bit AXI4-Lite slave, one aligned word per register
`ifndef ULPE_MAP_VH
`define ULPE_MAP_VH
// ----------------------------------------
// offsets
// ----------------------------------------
`define ULPE_OFF_CR1    8'h00
`define ULPE_OFF_CR2    8'h04
`define ULPE_OFF_SR     8'h08
`define ULPE_OFF_DIV    8'h0C
`define ULPE_OFF_RXBUF  8'h10
`define ULPE_OFF_TXBUF  8'h14
`define ULPE_OFF_IRQST  8'h18
`define ULPE_OFF_IRQMSK 8'h1C
`define ULPE_OFF_PWR    8'h20
// ----------------------------------------
// control one fields
// ----------------------------------------
`define ULPE_CR1_TXE    7
`define ULPE_CR1_RXE    6
`define ULPE_CR1_STOP   5
`define ULPE_CR1_EVEN   4
`define ULPE_CR1_PE     3
`define ULPE_CR1_IRSEL  2
`define ULPE_CR1_CLKSEL 1
`define ULPE_CR1_WMASK  8'hFE
// ----------------------------------------
// status fields
// ----------------------------------------
`define ULPE_SR_PARITY_ERROR_FLAG 7
`define ULPE_SR_FRAMING_ERROR_FLAG 6
`define ULPE_SR_OVERRUN_ERROR_FLAG 5
`define ULPE_SR_RBSY 3
`define ULPE_SR_RX_FULL_FLAG 2
`define ULPE_SR_TBSY 1
`define ULPE_SR_TX_FULL_FLAG 0
// ----------------------------------------
// power control fields
// ----------------------------------------
`define ULPE_PWR_STOP  0
`define ULPE_PWR_IDLE  1
`define ULPE_PWR_SLEEP 2
`define ULPE_PWR_OHOLD 3
// ----------------------------------------
// reset values, response codes and infrared pulse width
// ----------------------------------------
`define ULPE_RST_BYTE   8'h00
`define ULPE_RESP_OKAY  2'h0
`define ULPE_RESP_SLVERR 2'h2
`define ULPE_IR_PULSE_NUM 3
`define ULPE_IR_PULSE_DEN 16
`endif

// *** hdl/ulpe_serial.v ***
// serial port with automatic low-power entry, registers over AXI4-Lite
// assumes one clock aclk, a synchronous active-low reset and an rxd pin from off chip
// How it works
// - low-power entry halts transfers without software
// - entry clears enables, keeps format fields
// - entry clears status; divisor and control two kept
// - pin state applies whether busy or idle
// - idle or sleep: pin high, infrared low
// - stop with hold, idle or sleep acts idle, else released
// - infrared select sends pulse-coded transmit data
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "ulpe_map.vh"
module ulpe_serial #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              rxd,
  output reg               txd_o,
  output reg               txd_oe,
  output reg               irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_DONE  = 3'b100;
  reg [7:0]  cr1_q, cr2_q, div_q, rxbuf_q, txbuf_q, irq_st_q, irq_msk_q, pwr_q;
  reg        parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q, rbsy_q, rx_full_flag_q, tbsy_q, tx_full_flag_q;
  reg [2:0]  tx_st_q, rx_st_q;
  reg [10:0] tx_sh_q;
  reg [3:0]  tx_cnt_q, rx_cnt_q, tx_ph_q, rx_ph_q;
  reg [7:0]  tx_div_q, rx_div_q, rx_sh_q;
  reg        rxd_m_q, rxd_s_q, aw_got_q, w_got_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg        wstrb0_q;
  wire low_entry = pwr_q[`ULPE_PWR_STOP] | pwr_q[`ULPE_PWR_IDLE] | pwr_q[`ULPE_PWR_SLEEP];
  wire irsel = cr1_q[`ULPE_CR1_IRSEL];
  wire busy_any = tbsy_q | rbsy_q;
  wire [7:0] sr_w = {parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q, 1'b0, rbsy_q, rx_full_flag_q, tbsy_q, tx_full_flag_q};
  // ----------------------------------------
  // address match helper
  // ----------------------------------------
  function hit;
    input [ADDR_W-1:0] a;
    input [7:0]        off;
    begin
      hit = (a[7:2] == off[7:2]);
    end
  endfunction
  // ----------------------------------------
  // write channel
  // ----------------------------------------
  wire wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire wr_ok = hit(awaddr_q, `ULPE_OFF_CR1) | hit(awaddr_q, `ULPE_OFF_CR2) |
               hit(awaddr_q, `ULPE_OFF_DIV) | hit(awaddr_q, `ULPE_OFF_TXBUF) |
               hit(awaddr_q, `ULPE_OFF_IRQST) | hit(awaddr_q, `ULPE_OFF_IRQMSK) |
               hit(awaddr_q, `ULPE_OFF_PWR);
  wire we = wr_go & wr_ok & wstrb0_q;
  wire [7:0] wb = wdata_q[7:0];
  wire tx_load = we & hit(awaddr_q, `ULPE_OFF_TXBUF) & cr1_q[`ULPE_CR1_TXE] & ~low_entry;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ULPE_RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= {ADDR_W{1'b0}};
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_got_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_got_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_q  <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `ULPE_RESP_OKAY : `ULPE_RESP_SLVERR;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // registers; low-power entry wins over writes to control, divisor and transmit buffer
  // ----------------------------------------
  wire rx_done, tx_done, parity_error_flag_set, framing_error_flag_set, overrun_error_flag_set;
  wire [7:0] ev = {1'b0, 1'b0, 1'b0, rx_done, parity_error_flag_set, framing_error_flag_set, overrun_error_flag_set, tx_done};
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cr1_q     <= `ULPE_RST_BYTE;
      cr2_q     <= `ULPE_RST_BYTE;
      div_q     <= `ULPE_RST_BYTE;
      txbuf_q   <= `ULPE_RST_BYTE;
      irq_st_q  <= `ULPE_RST_BYTE;
      irq_msk_q <= `ULPE_RST_BYTE;
      pwr_q     <= `ULPE_RST_BYTE;
    end
    else
    begin
      if (we & hit(awaddr_q, `ULPE_OFF_PWR))
        pwr_q <= wb;
      if (low_entry)
        cr1_q <= cr1_q & 8'h3E;
      else if (we & hit(awaddr_q, `ULPE_OFF_CR1))
        // format fields frozen while a transfer runs
        cr1_q <= busy_any ? {wb[7:6], cr1_q[5:0]} : (wb & `ULPE_CR1_WMASK);
      if (we & hit(awaddr_q, `ULPE_OFF_CR2) & ~busy_any & ~low_entry)
        cr2_q <= wb;
      if (we & hit(awaddr_q, `ULPE_OFF_DIV) & ~low_entry)
        div_q <= wb;
      if (tx_load)
        txbuf_q <= wb;
      if (we & hit(awaddr_q, `ULPE_OFF_IRQMSK))
        irq_msk_q <= wb;
      // set wins over write-one-to-clear
      irq_st_q <= (irq_st_q & ~((we & hit(awaddr_q, `ULPE_OFF_IRQST)) ? wb : 8'h00)) | ev;
    end
  end
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  // >= so a smaller divisor never waits for the prescaler to wrap
  wire tx_tick = (tx_div_q >= div_q);
  wire par_bit = ^txbuf_q ^ ~cr1_q[`ULPE_CR1_EVEN];
  wire [3:0] tx_len = 4'd10 + {3'd0, cr1_q[`ULPE_CR1_PE]} + {3'd0, cr1_q[`ULPE_CR1_STOP]};
  reg  tx_line;
  assign tx_done = tx_st_q[2];
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st_q <= ST_IDLE;
      tbsy_q  <= 1'b0;
      tx_full_flag_q  <= 1'b0;
      tx_sh_q <= 11'h7FF;
      tx_cnt_q <= 4'h0;
      tx_ph_q <= 4'h0;
      tx_div_q <= 8'h00;
    end
    else if (low_entry)
    begin
      tx_st_q <= ST_IDLE;
      tbsy_q  <= 1'b0;
      tx_full_flag_q  <= 1'b0;
      tx_sh_q <= 11'h7FF;
    end
    else
    begin
      tx_div_q <= tx_tick ? 8'h00 : tx_div_q + 8'h01;
      if (tx_load)
        tx_full_flag_q <= 1'b1;
      case (tx_st_q)
        ST_IDLE:
          if (tx_full_flag_q & ~tx_load)
          begin
            tx_sh_q <= cr1_q[`ULPE_CR1_PE] ? {1'b1, par_bit, txbuf_q, 1'b0}
                                           : {2'b11, txbuf_q, 1'b0};
            tx_full_flag_q  <= 1'b0;
            tbsy_q  <= 1'b1;
            tx_cnt_q <= 4'h0;
            tx_ph_q <= 4'h0;
            tx_st_q <= ST_SHIFT;
          end
        ST_SHIFT:
          if (tx_tick)
          begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == 4'hF)
            begin
              tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
              tx_cnt_q <= tx_cnt_q + 4'h1;
              if (tx_cnt_q == tx_len - 4'h1)
                tx_st_q <= ST_DONE;
            end
          end
        ST_DONE:
        begin
          tbsy_q  <= 1'b0;
          tx_st_q <= ST_IDLE;
        end
        default:
          tx_st_q <= ST_IDLE;
      endcase
    end
  end
  // infrared: a short high pulse for each zero bit, low otherwise
  always @*
  begin
    if (irsel)
      tx_line = ~tx_sh_q[0] & (tx_ph_q < 4'd3);
    else
      tx_line = tx_sh_q[0];
  end
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  reg rx_par_q, rx_stop_q;
  wire rx_tick = (rx_div_q >= div_q);
  assign rx_done  = rx_st_q[2];
  assign parity_error_flag_set = rx_done & cr1_q[`ULPE_CR1_PE] & (^rx_sh_q ^ rx_par_q ^ ~cr1_q[`ULPE_CR1_EVEN]);
  assign framing_error_flag_set = rx_done & ~rx_stop_q;
  assign overrun_error_flag_set = rx_done & rx_full_flag_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end
    else
    begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end
  wire rd_rxbuf;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_st_q <= ST_IDLE;
      {parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q, rbsy_q, rx_full_flag_q} <= 5'h00;
      rx_sh_q <= 8'h00;
      rxbuf_q <= 8'h00;
      rx_cnt_q <= 4'h0;
      rx_ph_q <= 4'h0;
      rx_div_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_stop_q <= 1'b1;
    end
    else if (low_entry)
    begin
      rx_st_q <= ST_IDLE;
      {parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q, rbsy_q, rx_full_flag_q} <= 5'h00;
    end
    else
    begin
      rx_div_q <= rx_tick ? 8'h00 : rx_div_q + 8'h01;
      if (rd_rxbuf)
        rx_full_flag_q <= 1'b0;
      case (rx_st_q)
        ST_IDLE:
          if (cr1_q[`ULPE_CR1_RXE] & ~rxd_s_q)
          begin
            rbsy_q <= 1'b1;
            rx_cnt_q <= 4'h0;
            rx_ph_q <= 4'h0;
            rx_st_q <= ST_SHIFT;
          end
        ST_SHIFT:
          if (rx_tick)
          begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == 4'h7)
            begin
              rx_cnt_q <= rx_cnt_q + 4'h1;
              if (rx_cnt_q >= 4'h1 && rx_cnt_q <= 4'h8)
                rx_sh_q <= {rxd_s_q, rx_sh_q[7:1]};
              else if (rx_cnt_q == 4'h9 && cr1_q[`ULPE_CR1_PE])
                rx_par_q <= rxd_s_q;
              else if (rx_cnt_q != 4'h0)
              begin
                rx_stop_q <= rxd_s_q;
                rx_st_q   <= ST_DONE;
              end
            end
          end
        ST_DONE:
        begin
          rbsy_q <= 1'b0;
          rx_full_flag_q <= 1'b1;
          rxbuf_q <= rx_sh_q;
          parity_error_flag_q <= parity_error_flag_q | parity_error_flag_set;
          framing_error_flag_q <= framing_error_flag_q | framing_error_flag_set;
          overrun_error_flag_q <= overrun_error_flag_q | overrun_error_flag_set;
          rx_st_q <= ST_IDLE;
        end
        default:
          rx_st_q <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // read channel
  // ----------------------------------------
  reg [7:0] rd_byte;
  reg       rd_ok;
  assign rd_rxbuf = s_axi_arvalid & s_axi_arready & hit(s_axi_araddr, `ULPE_OFF_RXBUF);
  always @*
  begin
    rd_ok = 1'b1;
    rd_byte = 8'h00;
    if (hit(s_axi_araddr, `ULPE_OFF_CR1)) rd_byte = cr1_q;
    else if (hit(s_axi_araddr, `ULPE_OFF_CR2)) rd_byte = cr2_q;
    else if (hit(s_axi_araddr, `ULPE_OFF_SR)) rd_byte = sr_w;
    else if (hit(s_axi_araddr, `ULPE_OFF_DIV)) rd_byte = div_q;
    else if (hit(s_axi_araddr, `ULPE_OFF_RXBUF)) rd_byte = rxbuf_q;
    else if (hit(s_axi_araddr, `ULPE_OFF_TXBUF)) rd_byte = 8'h00;
    else if (hit(s_axi_araddr, `ULPE_OFF_IRQST)) rd_byte = irq_st_q;
    else if (hit(s_axi_araddr, `ULPE_OFF_IRQMSK)) rd_byte = irq_msk_q;
    else if (hit(s_axi_araddr, `ULPE_OFF_PWR)) rd_byte = pwr_q;
    else rd_ok = 1'b0;
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ULPE_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? `ULPE_RESP_OKAY : `ULPE_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // pin and interrupt outputs
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd_o  <= 1'b1;
      txd_oe <= 1'b1;
      irq    <= 1'b0;
    end
    else
    begin
      irq <= |(irq_st_q & irq_msk_q);
      // in low power the pin state follows mode only, never a frame in flight; otherwise it follows tx_line
      if (low_entry)
      begin
        txd_o  <= ~irsel;
        txd_oe <= ~pwr_q[`ULPE_PWR_STOP] | pwr_q[`ULPE_PWR_OHOLD] |
                  pwr_q[`ULPE_PWR_IDLE] | pwr_q[`ULPE_PWR_SLEEP];
      end
      else
      begin
        txd_o  <= tx_line;
        txd_oe <= 1'b1;
      end
    end
  end
endmodule // ulpe_serial

// *** dv/ulpe_remote.sv ***
// far-side serial device: sends 8N1 frames on rxd, decodes 8N1 frames on the line
// assumes the line idles high and one bit lasts BIT clocks of aclk
`timescale 1ns/100ps
module ulpe_remote #(
  parameter BIT = 16
) (
  input  wire       aclk,
  input  wire       line,
  output reg        rxd,
  output reg  [7:0] got
);
  integer j;
  integer n;
  initial rxd = 1'b1;
  initial got = 8'h00;
  task send(input [7:0] d);
    reg [9:0] f;
    begin
      f = {1'b1, d, 1'b0};
      for (j = 0; j < 10; j = j + 1)
      begin
        @(posedge aclk);
        rxd <= f[j];
        repeat (BIT - 1) @(posedge aclk);
      end
    end
  endtask
  // no glitch filter: a stray low level restarts a frame, so garbage is possible
  always
  begin
    @(negedge line);
    repeat (BIT + BIT / 2) @(posedge aclk);
    for (n = 0; n < 8; n = n + 1)
    begin
      got[n] = line;
      repeat (BIT) @(posedge aclk);
    end
  end
endmodule // ulpe_remote

// *** dv/ulpe_serial_checker.sv ***
// assertions on pin state, register clearing and bus timing of ulpe_serial
// assumes full-strobe writes; mode is shadowed from completed bus writes
`timescale 1ns/100ps
`include "ulpe_map.vh"
module ulpe_serial_checker #(
  parameter ADDR_W = 8
) (
  input wire              aclk,
  input wire              aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire [31:0]       s_axi_wdata,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire              s_axi_rvalid,
  input wire [31:0]       s_axi_rdata,
  input wire              txd_o,
  input wire              txd_oe
);
  reg [ADDR_W-1:0] wa_q;
  reg [ADDR_W-1:0] ra_q;
  reg [7:0]        wd_q;
  reg [3:0]        pwr_q;
  reg              ir_q;
  reg              wp_q;
  wire             lp  = |pwr_q[2:0];
  // a write in flight may move the pin, so checks wait for it to finish
  wire             ok  = lp && !wp_q;
  wire             rel = pwr_q[`ULPE_PWR_STOP] && !pwr_q[`ULPE_PWR_OHOLD];
  always @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      wd_q <= s_axi_wdata[7:0];
    if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
    if (!aresetn)
    begin
      pwr_q <= 4'h0;
      ir_q  <= 1'b0;
      wp_q  <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      wp_q <= 1'b0;
      if (wa_q == `ULPE_OFF_PWR)
        pwr_q <= wd_q[3:0];
      if (wa_q == `ULPE_OFF_CR1 && !lp)
        ir_q <= wd_q[`ULPE_CR1_IRSEL];
    end
    else if (s_axi_awvalid && s_axi_awready)
      wp_q <= 1'b1;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_pin_frozen: assert property (ok && $past(ok) |-> $stable(txd_o) && $stable(txd_oe))
    else $error("transmit pin moved in low power");
  a_enables_clear: assert property (s_axi_rvalid && ra_q == `ULPE_OFF_CR1 && ok
    |-> s_axi_rdata[7:6] == 2'h0) else $error("enables set in low power");
  a_status_clear: assert property (s_axi_rvalid && ra_q == `ULPE_OFF_SR && ok
    |-> s_axi_rdata == 32'h0) else $error("status not clear in low power");
  a_idle_level: assert property (ok && !rel |-> txd_oe && txd_o == !ir_q)
    else $error("wrong held transmit level");
  a_stop_release: assert property (ok && rel |-> !txd_oe)
    else $error("transmit pin not released in stop");
  a_ir_pulse: assert property ($rose(txd_o) && ir_q && !lp && !wp_q |-> ##[1:3] !txd_o)
    else $error("infrared pulse too long");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  c_released: cover property (ok && rel);
  c_ir_held: cover property (ok && !rel && ir_q);
  c_ir_pulse: cover property ($rose(txd_o) && ir_q && !lp);
endmodule // ulpe_serial_checker
bind ulpe_serial ulpe_serial_checker #(.ADDR_W(ADDR_W)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .txd_o(txd_o), .txd_oe(txd_oe)
);

// *** dv/ulpe_serial_tb.sv ***
// self-checking bench for ulpe_serial: bus, interrupt, frames, low-power entry
// assumes ulpe_remote on the pins and a pull-up on the transmit line
`timescale 1ns/100ps
`include "ulpe_map.vh"
module ulpe_serial_tb;
  reg         aclk    = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr  = 8'h00;
  reg  [7:0]  araddr  = 8'h00;
  reg  [31:0] wdata   = 32'h0;
  reg         awvalid = 1'b0;
  reg         wvalid  = 1'b0;
  reg         bready  = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready  = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid, txd_o, txd_oe, irq, rxd;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [7:0]  got;
  wire        line = txd_oe ? txd_o : 1'b1;
  reg  [31:0] q;
  reg  [1:0]  r;
  reg  [7:0]  b, c, dv;
  reg  [3:0]  m;
  reg  [15:0] mt = 16'h1429;
  integer     n_mismatch = 0, checked = 0, cyc = 0, i, k;
  ulpe_serial dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rxd(rxd), .txd_o(txd_o), .txd_oe(txd_oe), .irq(irq)
  );
  ulpe_remote rem_u (.aclk(aclk), .line(line), .rxd(rxd), .got(got));
  initial forever #5 aclk = ~aclk;
  function [1:0] pin_exp(input [3:0] md, input ir);
    pin_exp = (md[0] && !md[3]) ? 2'b00 : {1'b1, !ir};
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg ad, dd;
    begin
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      ad = 1'b0;
      dd = 1'b0;
      while (!(ad && dd))
      begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        ad = ad | awready;
        dd = dd | wready;
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      q = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  initial
  begin
    k = $urandom(34452);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h24);
    chk({30'h0, r}, {30'h0, `ULPE_RESP_SLVERR});
    wr(`ULPE_OFF_DIV, 32'h0);
    wr(`ULPE_OFF_IRQMSK, 32'h1);
    wr(`ULPE_OFF_CR1, 32'hC0);
    q = $urandom;
    b = q[7:0];
    wr(`ULPE_OFF_TXBUF, {24'h0, b});
    for (k = 0; k < 400 && irq !== 1'b1; k = k + 1)
      @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    repeat (200) @(posedge aclk);
    chk({24'h0, got}, {24'h0, b});
    wr(`ULPE_OFF_IRQMSK, 32'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(`ULPE_OFF_IRQST, 32'h1);
    rd(`ULPE_OFF_IRQST);
    chk(q, 32'h0);
    q = $urandom;
    b = q[7:0];
    rem_u.send(b);
    repeat (40) @(posedge aclk);
    rd(`ULPE_OFF_RXBUF);
    chk(q, {24'h0, b});
    for (i = 0; i < 8; i = i + 1)
    begin
      q  = $urandom;
      m  = mt[i[1:0]*4 +: 4];
      c  = {2'b11, q[2:0], i[2], 2'b00};
      dv = i[2] ? 8'h00 : q[15:8];
      wr(`ULPE_OFF_CR1, {24'h0, c & 8'h3C});
      wr(`ULPE_OFF_DIV, {24'h0, dv});
      wr(`ULPE_OFF_CR1, {24'h0, c});
      if (i[0] ^ i[2])
        wr(`ULPE_OFF_TXBUF, q);
      repeat (40) @(posedge aclk);
      wr(`ULPE_OFF_PWR, {28'h0, m});
      rd(`ULPE_OFF_CR1);
      chk(q, {24'h0, c & 8'h3E});
      rd(`ULPE_OFF_SR);
      chk(q, 32'h0);
      rd(`ULPE_OFF_DIV);
      chk(q, {24'h0, dv});
      chk({30'h0, txd_oe, txd_oe & txd_o}, {30'h0, pin_exp(m, c[2])});
      wr(`ULPE_OFF_PWR, 32'h0);
    end
    report_and_stop;
  end
endmodule // ulpe_serial_tb
